// ---- core/digipot_regs.svh ----
`ifndef DIGIPOT_REGS_SVH
`define DIGIPOT_REGS_SVH

// Slave address prefix, upper five bits (value arbitrary)
`define ADDR_PREFIX 5'h0A
`define ADDR_PREFIX_W 5
// Instruction byte field positions
`define INSTR_CHAN_BIT 7
`define INSTR_MID_BIT 6
`define INSTR_SHUTDOWN_PIN_N_BIT 5
`define INSTR_OUT1_BIT 4
`define INSTR_OUT2_BIT 3
// Reset values
`define WIPER_MIDSCALE 8'h80
`define LOGIC_OUT_RESET 1'h0
// Bits per byte on the wire
`define BITS_PER_BYTE 4'h8

`endif

// ---- core/digipot_pkg.sv ----
package digipot_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_INSTR = 3'b010,
        ST_DATA = 3'b011,
        ST_READ = 3'b100,
        ST_SKIP = 3'b101
    } frame_state_t;

endpackage

// ---- core/line_events_if.sv ----
`timescale 1ns/1ps

interface line_events_if;
    logic scl_level;
    logic sda_level;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    modport producer (
        output scl_level,
        output sda_level,
        output scl_rise,
        output scl_fall,
        output start_seen,
        output stop_seen
    );

    modport consumer (
        input scl_level,
        input sda_level,
        input scl_rise,
        input scl_fall,
        input start_seen,
        input stop_seen
    );
endinterface

// ---- core/line_sampler.sv ----
`timescale 1ns/1ps

module line_sampler (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    line_events_if.producer ev
);

    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_prev_r;
    logic sda_prev_r;

    ////////////////////////////////////////////////////////////////
    // Two-stage synchronisers; only stage two is read
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_prev_r <= 1'h1;
            sda_prev_r <= 1'h1;
        end
        else
        begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            sda_sync_r <= {sda_sync_r[0], sda_in};
            scl_prev_r <= scl_sync_r[1];
            sda_prev_r <= sda_sync_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////
    assign ev.scl_level = scl_prev_r;
    assign ev.sda_level = sda_prev_r;
    assign ev.scl_rise = scl_sync_r[1] & ~scl_prev_r;
    assign ev.scl_fall = ~scl_sync_r[1] & scl_prev_r;
    assign ev.start_seen = scl_sync_r[1] & scl_prev_r & sda_prev_r & ~sda_sync_r[1];
    assign ev.stop_seen = scl_sync_r[1] & scl_prev_r & ~sda_prev_r & sda_sync_r[1];

endmodule

// ---- core/digipot_ctrl.sv ----
// What this block does
// - Address byte: fixed prefix plus pin levels
// - START begins frame; next byte is address
// - Acknowledge only on matching address
// - Read/write bit: one reads, zero writes
// - Write has instruction byte; read has none
// - Instruction MSB selects wiper channel
// - Midscale bit centres selected wiper
// - Shutdown bit acts like shutdown pin
// - Two instruction bits drive logic outputs
// - Three low instruction bits ignored
// - Nine clocks per byte, MSB first
// - SDA changes only while SCL low
// - Read returns selected wiper, master NAKs
// - STOP returns device to idle
// - Each data byte updates selected wiper
// - Repeated reads return selected channel value
// - Readback uses channel of last instruction byte
// - Wiper code eight bits, 0 to 255
// - Shutdown pin acts through two-flop synchroniser
// - Wipers preset to midscale at reset
// - Logic outputs reset to zero
// - Leaving shutdown restores stored wiper
`timescale 1ns/1ps
`include "digipot_regs.svh"

module digipot_ctrl #(
    parameter int CHANNELS = 2
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_sel_pin_low,
    input wire logic addr_sel_pin_high,
    input wire logic shutdown_pin_n,
    output logic [7:0] wiper_register_first,
    output logic [7:0] wiper_register_second,
    output logic shutdown_active,
    output logic logic_out_one,
    output logic logic_out_two
);

    line_events_if ev ();

    line_sampler u_sampler (
        .clk(clk),
        .reset(reset),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ev(ev)
    );

    ////////////////////////////////////////////////////////////////
    // Frame state and bit counting

    digipot_pkg::frame_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic ack_phase_r;
    logic ack_drive_r;
    logic read_active_r;
    logic nak_seen_r;
    logic addr_ok;
    logic [7:0] byte_in;
    logic byte_done;
    logic [1:0] addr_sel_sync_r;
    logic [1:0] addr_sel_r;

    logic chan_sel_r;
    logic shutdown_pin_n_bit_r;
    logic [7:0] wiper_r [0:1];
    logic [1:0] shutdown_pin_n_pin_sync_r;

    // Address-select pins are slow straps but still cross domains
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            addr_sel_sync_r <= 2'h0;
            addr_sel_r <= 2'h0;
        end
        else
        begin
            addr_sel_sync_r <= {addr_sel_pin_high, addr_sel_pin_low};
            addr_sel_r <= addr_sel_sync_r;
        end
    end

    assign byte_in = {shift_r[6:0], ev.sda_level};
    assign byte_done = ev.scl_rise & ~ack_phase_r & (bit_cnt_r == (`BITS_PER_BYTE - 4'h1));
    assign addr_ok = (byte_in[7:3] == `ADDR_PREFIX) && (byte_in[2:1] == addr_sel_r);

    // Bit counter: eight data bits then one acknowledge slot
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            bit_cnt_r <= 4'h0;
            ack_phase_r <= 1'h0;
            shift_r <= 8'h00;
        end
        // abandon byte on START or STOP
        else if (ev.start_seen || ev.stop_seen)
        begin
            bit_cnt_r <= 4'h0;
            ack_phase_r <= 1'h0;
        end
        else if (ev.scl_rise && !ack_phase_r)
        begin
            shift_r <= byte_in;
            if (bit_cnt_r == (`BITS_PER_BYTE - 4'h1))
            begin
                bit_cnt_r <= 4'h0;
                ack_phase_r <= 1'h1;
            end
            else
            begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
        end
        else if (ev.scl_fall && ack_phase_r && bit_cnt_r == 4'h0)
        begin
            // Falling edge ending bit eight opens the ack slot
            bit_cnt_r <= 4'h1;
        end
        else if (ev.scl_fall && ack_phase_r)
        begin
            // Falling edge after the ninth clock closes it
            bit_cnt_r <= 4'h0;
            ack_phase_r <= 1'h0;
        end
    end

    // Frame sequencing
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_r <= digipot_pkg::ST_IDLE;
        end
        else if (ev.start_seen)
        begin
            state_r <= digipot_pkg::ST_ADDR;
        end
        else if (ev.stop_seen)
        begin
            state_r <= digipot_pkg::ST_IDLE;
        end
        else if (byte_done)
        begin
            case (state_r)
                digipot_pkg::ST_ADDR:
                begin
                    if (!addr_ok)
                        state_r <= digipot_pkg::ST_SKIP;
                    else if (byte_in[0])
                        state_r <= digipot_pkg::ST_READ;
                    else
                        state_r <= digipot_pkg::ST_INSTR;
                end
                digipot_pkg::ST_INSTR:
                begin
                    state_r <= digipot_pkg::ST_DATA;
                end
                digipot_pkg::ST_DATA:
                begin
                    state_r <= digipot_pkg::ST_DATA;
                end
                default:
                begin
                    state_r <= state_r;
                end
            endcase
        end
        // NAK from master ends the read
        else if (state_r == digipot_pkg::ST_READ && nak_seen_r)
        begin
            state_r <= digipot_pkg::ST_SKIP;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Instruction and wiper registers

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            chan_sel_r <= 1'h0;
            shutdown_pin_n_bit_r <= 1'h0;
            logic_out_one <= `LOGIC_OUT_RESET;
            logic_out_two <= `LOGIC_OUT_RESET;
        end
        else if (byte_done && state_r == digipot_pkg::ST_INSTR)
        begin
            // channel select; single channel forces zero
            chan_sel_r <= (CHANNELS > 1) ? byte_in[`INSTR_CHAN_BIT] : 1'h0;
            shutdown_pin_n_bit_r <= byte_in[`INSTR_SHUTDOWN_PIN_N_BIT];
            logic_out_one <= byte_in[`INSTR_OUT1_BIT];
            logic_out_two <= byte_in[`INSTR_OUT2_BIT];
        end
    end
    // chan_sel_r not touched by START, STOP or address

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wiper_r[0] <= `WIPER_MIDSCALE;
            wiper_r[1] <= `WIPER_MIDSCALE;
        end
        else if (byte_done && state_r == digipot_pkg::ST_INSTR && byte_in[`INSTR_MID_BIT])
        begin
            wiper_r[(CHANNELS > 1) ? byte_in[`INSTR_CHAN_BIT] : 1'h0] <= `WIPER_MIDSCALE;
        end
        else if (byte_done && state_r == digipot_pkg::ST_DATA)
        begin
            wiper_r[chan_sel_r] <= byte_in;
        end
    end

    // Wiper outputs hold stored codes; shutdown never alters them
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wiper_register_first <= `WIPER_MIDSCALE;
            wiper_register_second <= `WIPER_MIDSCALE;
        end
        else
        begin
            wiper_register_first <= wiper_r[0];
            wiper_register_second <= wiper_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Shutdown. The pin is synchronised so the output stays a flop;
    // the analog path is expected to use the pin directly as well.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            shutdown_pin_n_pin_sync_r <= 2'h3;
            shutdown_active <= 1'h0;
        end
        else
        begin
            shutdown_pin_n_pin_sync_r <= {shutdown_pin_n_pin_sync_r[0], shutdown_pin_n};
            shutdown_active <= ~shutdown_pin_n_pin_sync_r[1] | shutdown_pin_n_bit_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    // SDA driver: ack slots and read data only

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ack_drive_r <= 1'h0;
            read_active_r <= 1'h0;
            tx_r <= 8'hFF;
            nak_seen_r <= 1'h0;
        end
        else if (ev.start_seen || ev.stop_seen)
        begin
            ack_drive_r <= 1'h0;
            read_active_r <= 1'h0;
            nak_seen_r <= 1'h0;
        end
        // Drive flags move on SCL falls; START or STOP clears them while SCL is high
        else if (ev.scl_fall)
        begin
            ack_drive_r <= 1'h0;
            if (ack_phase_r && bit_cnt_r == 4'h0)
            begin
                // Read data ends here so the master can NAK
                read_active_r <= 1'h0;
                // ack only when matched and addressed
                ack_drive_r <= (state_r == digipot_pkg::ST_INSTR) || (state_r == digipot_pkg::ST_DATA)
                    || (state_r == digipot_pkg::ST_READ && !read_active_r);
                // load current selected value per read
                if (state_r == digipot_pkg::ST_READ && !read_active_r)
                    tx_r <= wiper_r[chan_sel_r];
            end
            else if (ack_phase_r)
            begin
                // Data bits follow only our own read address ack
                read_active_r <= (state_r == digipot_pkg::ST_READ) && ack_drive_r;
            end
            else if (read_active_r && bit_cnt_r != 4'h0)
            begin
                tx_r <= {tx_r[6:0], 1'h1};
            end
        end
        else if (ev.scl_rise && ack_phase_r && bit_cnt_r == 4'h1 && state_r == digipot_pkg::ST_READ)
        begin
            nak_seen_r <= ev.sda_level;
        end
    end

    // drive only in own ack or read-data slots
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sda_oe <= 1'h0;
            sda_out <= 1'h1;
        end
        else
        begin
            sda_out <= 1'h0;
            // released for master NAK and STOP
            sda_oe <= ~ev.start_seen & ~ev.stop_seen & (ack_drive_r | (read_active_r & ~tx_r[7]));
        end
    end

endmodule

// ---- verif/bus_master_model.sv ----
`timescale 1ns/1ps
module bus_master_model (
    input wire logic clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_low
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic start();
        cyc(1);
        sda_low <= 1'b0;
        cyc(5);
        scl <= 1'b1;
        cyc(3);
        sda_low <= 1'b1;
        cyc(3);
        scl <= 1'b0;
    endtask
    task automatic stop();
        cyc(1);
        sda_low <= 1'b1;
        cyc(4);
        scl <= 1'b1;
        cyc(3);
        sda_low <= 1'b0;
        cyc(4);
    endtask
    task automatic put(input logic b, output logic s);
        cyc(1);
        sda_low <= !b;
        cyc(4);
        scl <= 1'b1;
        cyc(2);
        s = sda_wire;
        cyc(1);
        scl <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            put(b[i], s);
        put(1'b1, s);
        ack = !s;
    endtask
    task automatic rd(output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--)
            put(1'b1, v[i]);
        put(1'b1, s);
    endtask
endmodule

// ---- verif/digipot_ctrl_asserts.sv ----
`timescale 1ns/1ps
`include "digipot_regs.svh"
module digipot_ctrl_asserts (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic shutdown_pin_n,
    input wire logic [7:0] wiper_register_first,
    input wire logic [7:0] wiper_register_second,
    input wire logic shutdown_active,
    input wire logic logic_out_one,
    input wire logic logic_out_two
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////
    // open drain
    a_oe_drives_low: assert property (sda_oe |-> !sda_out)
        else $error("SDA driven high");
    a_reset_wipers: assert property (disable iff (1'b0) reset |=>
        wiper_register_first == `WIPER_MIDSCALE && wiper_register_second == `WIPER_MIDSCALE)
        else $error("wiper not midscale after reset");
    a_reset_quiet: assert property (disable iff (1'b0) reset |=>
        !logic_out_one && !logic_out_two && !sda_oe)
        else $error("outputs not low after reset");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_in, 3))
        else $error("SDA drive moved late");
    a_oe_stable_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("SDA drive moved in high");
    a_shutdown_pin_n_pin: assert property (!shutdown_pin_n |-> ##[1:5] shutdown_active)
        else $error("shutdown pin ignored");
    a_wiper_timing: assert property ($changed(wiper_register_first) ||
        $changed(wiper_register_second) |-> $past(scl_in, 1) || $past(scl_in, 2))
        else $error("wiper moved off bus");
    a_outs_timing: assert property ($changed(logic_out_one) ||
        $changed(logic_out_two) |-> $past(scl_in, 1) || $past(scl_in, 2))
        else $error("logic output moved off bus");
endmodule
bind digipot_ctrl digipot_ctrl_asserts u_asserts (.clk(clk), .reset(reset), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .shutdown_pin_n(shutdown_pin_n),
    .wiper_register_first(wiper_register_first), .wiper_register_second(wiper_register_second),
    .shutdown_active(shutdown_active), .logic_out_one(logic_out_one), .logic_out_two(logic_out_two));

// ---- verif/i2c_digital_pot_control_bench.sv ----
`timescale 1ns/1ps
`include "digipot_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module i2c_digital_pot_control_bench;
    logic clk, reset, ph, pl, shutdown_pin_n_n, scl, sda_low, sda_wire, sda_out, sda_oe, sd_act, o1, o2, a;
    logic [7:0] w1, w2, v;
    int errors = 0;
    int cmp_count = 0;
    assign sda_wire = !(sda_low || (sda_oe && !sda_out));
    digipot_ctrl #(.CHANNELS(2)) u_dut (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_pin_low(pl), .addr_sel_pin_high(ph),
        .shutdown_pin_n(shutdown_pin_n_n), .wiper_register_first(w1), .wiper_register_second(w2),
        .shutdown_active(sd_act), .logic_out_one(o1), .logic_out_two(o2));
    bus_master_model u_m (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [7:0] adr(input logic rw);
        return {`ADDR_PREFIX, ph, pl, rw};
    endfunction
    // Data bytes count up from d
    task automatic wcmd(input logic [7:0] ins, input logic [7:0] d, input int n, input logic sp);
        u_m.start();
        u_m.wr(adr(1'b0), a);
        `CHK("addr ack", 1'b1, a)
        u_m.wr(ins, a);
        `CHK("instr ack", 1'b1, a)
        for (int i = 0; i < n; i++)
        begin
            u_m.wr(d + 8'(i), a);
            `CHK("data ack", 1'b1, a)
        end
        if (sp)
            u_m.stop();
        u_m.cyc(4);
    endtask
    task automatic rdv(input logic [7:0] e);
        u_m.start();
        u_m.wr(adr(1'b1), a);
        `CHK("read ack", 1'b1, a)
        u_m.rd(v);
        u_m.stop();
        `CHK("read data", e, v)
    endtask
    task automatic wait_sd(input logic e);
        int i;
        for (i = 0; i < 10 && sd_act !== e; i++)
            @(posedge clk);
        if (i == 10)
        begin
            errors++;
            stop_test();
        end
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_write();
        `CHK("w1 reset", `WIPER_MIDSCALE, w1)
        `CHK("outs reset", 2'b00, {o1, o2})
        wcmd(8'h17, 8'h3C, 2, 1'b1);
        `CHK("w1", 8'h3D, w1)
        `CHK("w2", `WIPER_MIDSCALE, w2)
        `CHK("outs", 2'b10, {o1, o2})
        wcmd(8'h8F, 8'h5A, 1, 1'b0);
        rdv(8'h5A);
        rdv(8'h5A);
        `CHK("outs", 2'b01, {o1, o2})
        wcmd(8'h00, 8'h00, 0, 1'b0);
        rdv(8'h3D);
        wcmd(8'hC0, 8'h00, 0, 1'b1);
        `CHK("w2 mid", `WIPER_MIDSCALE, w2)
        $display("t_write done");
    endtask
    task automatic t_shutdown_pin_n();
        wcmd(8'h20, 8'h00, 0, 1'b1);
        `CHK("sd bit", 1'b1, sd_act)
        `CHK("w1 kept", 8'h3D, w1)
        wcmd(8'h00, 8'h00, 0, 1'b1);
        `CHK("sd off", 1'b0, sd_act)
        `CHK("w1 back", 8'h3D, w1)
        shutdown_pin_n_n <= 1'b0;
        wait_sd(1'b1);
        `CHK("sd pin", 1'b1, sd_act)
        shutdown_pin_n_n <= 1'b1;
        wait_sd(1'b0);
        $display("t_shutdown_pin_n done");
    endtask
    // Old address after the pins move
    task automatic t_addr();
        logic [7:0] ao;
        ao = adr(1'b0);
        ph <= !ph;
        pl <= !pl;
        u_m.cyc(6);
        u_m.start();
        u_m.wr(ao, a);
        `CHK("stale ack", 1'b0, a)
        u_m.wr(8'h20, a);
        u_m.stop();
        `CHK("ignored", 1'b0, sd_act)
        wcmd(8'h00, 8'hFF, 1, 1'b1);
        `CHK("w1 max", 8'hFF, w1)
        $display("t_addr done");
    endtask
    // Cut a data byte by STOP, then by a repeated START
    task automatic t_abort();
        logic s;
        for (int k = 0; k < 2; k++)
        begin
            u_m.start();
            u_m.wr(adr(1'b0), a);
            u_m.wr(8'h00, a);
            for (int i = 0; i < 4; i++)
                u_m.put(1'b0, s);
            if (k == 0)
                u_m.stop();
            u_m.cyc(4);
            `CHK("w1 abort", 8'hFF, w1)
            rdv(8'hFF);
        end
        $display("t_abort done");
    endtask
    initial
    begin
        reset = 1'b1;
        ph = 1'b1;
        pl = 1'b0;
        shutdown_pin_n_n = 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        t_write();
        t_shutdown_pin_n();
        t_addr();
        t_abort();
        stop_test();
    end
endmodule
